/* File: design/dadc_offset_corr.sv */
// offset removal and calibration code forming for one channel
`timescale 1ns/1ps
module dadc_offset_corr #(
    parameter int CW = dadc_pkg::CODE_W
) (
    input  wire logic [CW-1:0] raw_code,
    input  wire logic [CW-1:0] ofs_code,
    output logic      [CW-1:0] corr_code,
    output logic      [CW-1:0] cal_code
);
    import dadc_pkg::*;

    localparam logic [CW-2:0] MAG_LIM = (CW-1)'(OFS_MAX_MAG);
    localparam logic signed [CW+1:0] MAXV = {3'b000, {(CW-1){1'b1}}};
    localparam logic signed [CW+1:0] MINV = {3'b111, {(CW-1){1'b0}}};

    if (CW < 9) begin : g_bad_width
        $error("dadc_offset_corr code width too small for offset range");
    end

    // sign-magnitude offset to signed value, limited in size
    function automatic logic signed [CW+1:0] sm_value(input logic [CW-1:0] sm);
        logic [CW-2:0] mag;
        mag = (sm[CW-2:0] > MAG_LIM) ? MAG_LIM : sm[CW-2:0];
        return sm[CW-1] ? -$signed({3'b000, mag}) : $signed({3'b000, mag});
    endfunction : sm_value

    logic signed [CW+1:0] raw_ext;
    logic signed [CW+1:0] diff;
    logic signed [CW+1:0] abs_v;

    // subtract offset, saturate to code range
    always_comb begin
        raw_ext = {{2{raw_code[CW-1]}}, raw_code};
        diff    = raw_ext - sm_value(ofs_code);
        if (diff > MAXV) begin
            corr_code = MAXV[CW-1:0];
        end else if (diff < MINV) begin
            corr_code = MINV[CW-1:0];
        end else begin
            corr_code = diff[CW-1:0];
        end
    end

    // shorted-input code to sign-magnitude offset
    always_comb begin
        abs_v    = raw_code[CW-1] ? -raw_ext : raw_ext;
        cal_code = {raw_code[CW-1],
                    (abs_v > $signed({3'b000, MAG_LIM})) ? MAG_LIM : abs_v[CW-2:0]};
    end
endmodule : dadc_offset_corr

/* File: design/dadc_pin_sync.sv */
// two-flop pin synchroniser with edge pulses
`timescale 1ns/1ps
module dadc_pin_sync #(
    parameter int           W   = 3,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    import dadc_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // refuse an empty group
    if (W < 1) begin : g_bad_width
        $error("dadc_pin_sync needs at least one pin");
    end

    // first stage feeds only the second; reset to idle levels, no false edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= RST;
            sync_r <= RST;
            prev_r <= RST;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // edges seen on the settled copy
    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = prev_r & ~sync_r;
endmodule : dadc_pin_sync

/* File: design/dadc_pkg.sv */
// shared constants and types for the dual converter readout block
package dadc_pkg;
    // result and offset code width
    localparam int CODE_W = 12;
    // falling serial clock edges counted from chip select fall
    localparam int CNT_W        = 6;
    localparam int EDGE_MSB     = 19;
    localparam int EDGE_LSB     = 30;
    localparam int EDGE_STD_END = 31;
    localparam int EXTRA_EDGES  = 14;
    localparam int EDGE_EXT_END = 47;
    localparam int PAIR_W       = 2 * CODE_W;
    // offset correction limit in result codes
    localparam int OFS_MAX_MAG  = 128;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_RESULT = 4'h0;
    localparam logic [3:0] IDX_CTRL   = 4'h1;
    localparam logic [3:0] IDX_OFS_A  = 4'h2;
    localparam logic [3:0] IDX_OFS_B  = 4'h3;
    localparam int         IDX_LSB    = 2;
    localparam int         IDX_MSB    = 5;
    // control register fields
    localparam int          CTRL_CAL_BIT = 7;
    localparam int          CTRL_SEL_LSB = 8;
    localparam int          CTRL_SEL_MSB = 11;
    localparam logic [11:0] CTRL_RST     = 12'h000;
    localparam logic [11:0] OFS_RST      = 12'h000;
    // host pin idle levels: calibration low, clock parked high, select high
    localparam logic [2:0]  PIN_IDLE     = 3'h3;
    // result register fields
    localparam int RES_B_LSB       = 16;
    localparam int STAT_CAL_BIT    = 29;
    localparam int STAT_BAD_BIT    = 30;
    localparam int STAT_BUSY_BIT   = 31;
    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;
    // readout sequence
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SHIFT, ST_QUIET} dadc_state_t;
endpackage : dadc_pkg

/* File: design/dadc_readout.sv */
// dual converter serial readout, offset calibration and register slave
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dadc_readout (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic                          chip_select_n,
    input  wire logic                          serial_clk,
    input  wire logic                          offset_cal_pin,
    input  wire logic [dadc_pkg::CODE_W-1:0]   conv_code_a,
    input  wire logic [dadc_pkg::CODE_W-1:0]   conv_code_b,
    output logic                               result_out_chan_a,
    output logic                               result_out_chan_a_oe,
    output logic                               result_out_chan_b,
    output logic                               result_out_chan_b_oe,
    output logic                               track_hold,
    output logic                               short_inputs
);
    import dadc_pkg::*;

    logic [2:0]        pin_lvl;
    logic [2:0]        pin_rise;
    logic [2:0]        pin_fall;
    logic              cs_low;
    logic              cs_fall;
    logic              cs_rise;
    logic              sclk_fall;
    logic              cal_pin_lvl;
    logic              cal_pin_rise;
    dadc_state_t       state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              edge_ev;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [CODE_W-1:0] corr_a;
    logic [CODE_W-1:0] corr_b;
    logic [CODE_W-1:0] cal_a;
    logic [CODE_W-1:0] cal_b;
    logic [CODE_W-1:0] res_a_r;
    logic [CODE_W-1:0] res_b_r;
    logic [PAIR_W-1:0] shf_a_r;
    logic [PAIR_W-1:0] shf_b_r;
    logic              cal_cyc_r;
    logic              bad_r;
    logic [11:0]       ctrl_r;
    logic [11:0]       ofs_a_r;
    logic [11:0]       ofs_b_r;
    logic              wr_pend_r;
    logic [3:0]        wr_idx_r;
    logic              addr_ok;
    logic              cal_store;
    logic              sw_wr;
    logic              sw_cal_set;

    // settle the three host pins
    dadc_pin_sync #(.W(3), .RST(PIN_IDLE)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({offset_cal_pin, serial_clk, chip_select_n}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign cs_low       = ~pin_lvl[0];
    assign cs_fall      = pin_fall[0];
    assign cs_rise      = pin_rise[0];
    assign sclk_fall    = pin_fall[1];
    assign cal_pin_lvl  = pin_lvl[2];
    assign cal_pin_rise = pin_rise[2];

    // per-channel offset removal
    dadc_offset_corr #(.CW(CODE_W)) u_corr_a (
        .raw_code  (conv_code_a),
        .ofs_code  (ofs_a_r),
        .corr_code (corr_a),
        .cal_code  (cal_a)
    );
    dadc_offset_corr #(.CW(CODE_W)) u_corr_b (
        .raw_code  (conv_code_b),
        .ofs_code  (ofs_b_r),
        .corr_code (corr_b),
        .cal_code  (cal_b)
    );

    // counted falling edges; one arriving with the select fall is dropped
    assign edge_ev = sclk_fall && cs_low && !cs_fall && state_r != ST_IDLE;
    assign cnt_nxt = (cnt_r == {CNT_W{1'b1}}) ? cnt_r : cnt_r + 1'b1;

    // readout sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else if (cs_rise) begin
            state_r <= ST_IDLE;
        end else if (cs_fall) begin
            state_r <= ST_CONV;
        end else if (edge_ev) begin
            case (state_r)
                ST_CONV: begin
                    if (cnt_nxt == CNT_W'(EDGE_MSB)) state_r <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (cnt_nxt == CNT_W'(EDGE_EXT_END)) state_r <= ST_QUIET;
                end
                default: state_r <= state_r;
            endcase
        end
    end

    // edge counter, restarted at each select fall
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (cs_fall) begin
            cnt_r <= '0;
        end else if (edge_ev) begin
            cnt_r <= cnt_nxt;
        end
    end

    // hold from select fall to edge 19
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            track_hold <= 1'b0;
        end else if (cs_fall) begin
            track_hold <= 1'b1;
        end else if (cs_rise || (edge_ev && cnt_nxt == CNT_W'(EDGE_MSB))) begin
            track_hold <= 1'b0;
        end
    end

    // output shifters: own result then the other channel's
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shf_a_r              <= '0;
            shf_b_r              <= '0;
            result_out_chan_a    <= 1'b0;
            result_out_chan_b    <= 1'b0;
            result_out_chan_a_oe <= 1'b0;
            result_out_chan_b_oe <= 1'b0;
            res_a_r              <= '0;
            res_b_r              <= '0;
        end else if (cs_rise || cs_fall) begin
            result_out_chan_a_oe <= 1'b0;
            result_out_chan_b_oe <= 1'b0;
        end else if (edge_ev && state_r == ST_CONV && cnt_nxt == CNT_W'(EDGE_MSB)) begin
            res_a_r              <= corr_a;
            res_b_r              <= corr_b;
            result_out_chan_a    <= corr_a[CODE_W-1];
            result_out_chan_b    <= corr_b[CODE_W-1];
            result_out_chan_a_oe <= 1'b1;
            result_out_chan_b_oe <= 1'b1;
            shf_a_r              <= {corr_a[CODE_W-2:0], corr_b, 1'b0};
            shf_b_r              <= {corr_b[CODE_W-2:0], corr_a, 1'b0};
        end else if (edge_ev && state_r == ST_SHIFT) begin
            if (cnt_nxt == CNT_W'(EDGE_EXT_END)) begin
                result_out_chan_a_oe <= 1'b0;
                result_out_chan_b_oe <= 1'b0;
            end
            result_out_chan_a <= shf_a_r[PAIR_W-1];
            result_out_chan_b <= shf_b_r[PAIR_W-1];
            shf_a_r           <= {shf_a_r[PAIR_W-2:0], 1'b0};
            shf_b_r           <= {shf_b_r[PAIR_W-2:0], 1'b0};
        end
    end

    // calibration cycle chosen at select fall from pin or control bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_cyc_r    <= 1'b0;
            short_inputs <= 1'b0;
        end else if (cs_fall) begin
            cal_cyc_r    <= cal_pin_lvl || ctrl_r[CTRL_CAL_BIT];
            short_inputs <= cal_pin_lvl || ctrl_r[CTRL_CAL_BIT];
        end else if (cal_store || cs_rise) begin
            cal_cyc_r    <= 1'b0;
            short_inputs <= 1'b0;
        end
    end

    // calibration finishes on edge 19 of its own cycle
    assign cal_store = cal_cyc_r && edge_ev && state_r == ST_CONV
                       && cnt_nxt == CNT_W'(EDGE_MSB);

    // a pin rise or control request mid conversion spoils that result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_r <= 1'b0;
        end else if (cs_fall) begin
            bad_r <= 1'b0;
        end else if (state_r == ST_CONV && (cal_pin_rise || sw_cal_set)) begin
            bad_r <= 1'b1;
        end
    end

    // bus address phase qualifier and data phase write strobes
    assign addr_ok    = haddr[31:IDX_MSB+1] == '0 && haddr[1:0] == 2'h0;
    assign sw_wr      = wr_pend_r;
    assign sw_cal_set = sw_wr && wr_idx_r == IDX_CTRL && hwdata[CTRL_CAL_BIT];

    // register contents seen by a read
    function automatic logic [31:0] reg_read(input logic [3:0] idx);
        logic [31:0] v;
        v = '0;
        case (idx)
            IDX_RESULT: begin
                v[CODE_W-1:0]                  = res_a_r;
                v[RES_B_LSB +: CODE_W]         = res_b_r;
                v[STAT_CAL_BIT]                = cal_cyc_r;
                v[STAT_BAD_BIT]                = bad_r;
                v[STAT_BUSY_BIT]               = state_r == ST_CONV;
            end
            IDX_CTRL:  v[11:0] = ctrl_r;
            IDX_OFS_A: v[11:0] = ofs_a_r;
            IDX_OFS_B: v[11:0] = ofs_b_r;
            default:   v = '0;
        endcase
        return v;
    endfunction : reg_read

    // zero-wait slave: address phase latched, write done in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            if (hready) begin
                wr_pend_r <= hsel && htrans[1] && hwrite && addr_ok && hsize == HSIZE_WORD;
                wr_idx_r  <= haddr[IDX_MSB:IDX_LSB];
                hrdata    <= (hsel && htrans[1] && !hwrite && addr_ok)
                             ? reg_read(haddr[IDX_MSB:IDX_LSB]) : 32'h0000_0000;
            end
        end
    end

    // control register; hardware clear of the request loses to a new set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
        end else if (sw_wr && wr_idx_r == IDX_CTRL) begin
            ctrl_r <= hwdata[11:0];
        end else if (cal_store) begin
            ctrl_r[CTRL_CAL_BIT] <= 1'b0;
        end
    end

    // offsets: calibration result wins over a same-cycle write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ofs_a_r <= OFS_RST;
            ofs_b_r <= OFS_RST;
        end else if (cal_store) begin
            ofs_a_r <= cal_a;
            ofs_b_r <= cal_b;
        end else if (sw_wr && wr_idx_r == IDX_OFS_A) begin
            ofs_a_r <= hwdata[11:0];
        end else if (sw_wr && wr_idx_r == IDX_OFS_B) begin
            ofs_b_r <= hwdata[11:0];
        end
    end

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_hold_start;
        cs_fall |=> track_hold && state_r == ST_CONV;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("no hold after select fall");

    property p_quiet_conv;
        state_r == ST_CONV |-> !result_out_chan_a_oe && !result_out_chan_b_oe;
    endproperty
    a_quiet_conv: assert property (p_quiet_conv) else $error("output on during conversion");

    property p_msb_19;
        edge_ev && state_r == ST_CONV && cnt_r == CNT_W'(EDGE_MSB - 1)
        |=> result_out_chan_a_oe && !track_hold && result_out_chan_a == $past(corr_a[CODE_W-1]);
    endproperty
    a_msb_19: assert property (p_msb_19) else $error("msb not driven on edge 19");

    property p_shift_bit;
        edge_ev && state_r == ST_SHIFT && cnt_r < CNT_W'(EDGE_LSB)
        |=> result_out_chan_b == $past(shf_b_r[PAIR_W-1]) && result_out_chan_b_oe;
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("wrong bit shifted out");

    property p_cs_rise_off;
        cs_rise |=> !result_out_chan_a_oe && !result_out_chan_b_oe;
    endproperty
    a_cs_rise_off: assert property (p_cs_rise_off) else $error("outputs on after select rise");

    property p_end_47;
        edge_ev && state_r == ST_SHIFT && cnt_r == CNT_W'(EDGE_EXT_END - 1)
        |=> !result_out_chan_a_oe ##1 !result_out_chan_a_oe;
    endproperty
    a_end_47: assert property (p_end_47) else $error("output on after edge 47");

    property p_coincide;
        cs_fall && sclk_fall |=> cnt_r == '0;
    endproperty
    a_coincide: assert property (p_coincide) else $error("coincident clock edge counted");

    property p_cal_start;
        cs_fall && cal_pin_lvl |=> short_inputs && cal_cyc_r;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration not started");

    property p_cal_store;
        cal_store |=> ofs_a_r == $past(cal_a) && ofs_b_r == $past(cal_b) && !short_inputs;
    endproperty
    a_cal_store: assert property (p_cal_store) else $error("calibration code not stored");

    property p_ofs_keep;
        !cal_store && !sw_wr |=> $stable(ofs_a_r) && $stable(ofs_b_r);
    endproperty
    a_ofs_keep: assert property (p_ofs_keep) else $error("offset changed without cause");

    property p_bad_mid;
        state_r == ST_CONV && cal_pin_rise && !cs_fall && !cs_rise |=> bad_r;
    endproperty
    a_bad_mid: assert property (p_bad_mid) else $error("mid conversion pin rise not flagged");
endmodule : dadc_readout

/* File: tb/dadc_host_model.sv */
// host serial port model: select, serial clock, calibration pin, capture
`timescale 1ns/1ps
module dadc_host_model (
    input  wire logic hclk,
    output logic      chip_select_n,
    output logic      serial_clk,
    output logic      offset_cal_pin,
    input  wire logic result_out_chan_a,
    input  wire logic result_out_chan_a_oe,
    input  wire logic result_out_chan_b,
    input  wire logic result_out_chan_b_oe,
    input  wire logic track_hold,
    input  wire logic short_inputs
);
    import dadc_pkg::*;
    logic              tgl = 1'b0;
    logic              line_a, line_b, early_oe, hold_ok, short_seen, end_oe, cs_oe;
    logic [PAIR_W-1:0] cap_a, cap_b;
    // idle: select high, clock parked high
    initial {chip_select_n, serial_clk, offset_cal_pin} = 3'h6;
    // released line shows a changing pattern, never the last bit
    always @(posedge hclk) tgl <= ~tgl;
    assign line_a = result_out_chan_a_oe ? result_out_chan_a : tgl;
    assign line_b = result_out_chan_b_oe ? result_out_chan_b : tgl;
    task automatic grab();
        cap_a = {cap_a[PAIR_W-2:0], line_a};
        cap_b = {cap_b[PAIR_W-2:0], line_b};
    endtask : grab
    // pin moved only between frames; converters never powered down
    task automatic set_cal(input logic v);
        @(posedge hclk);
        offset_cal_pin <= v;
    endtask : set_cal
    // one frame of n serial clocks, 25 hclk each
    task automatic frame(input int n, input logic rise_cap, input logic coinc);
        int k;
        @(posedge hclk);
        {early_oe, short_seen, cap_a, cap_b} = '0;
        hold_ok = 1'b1;
        chip_select_n <= 1'b0;
        if (coinc) begin
            serial_clk <= 1'b0;
            repeat (12) @(posedge hclk);
            serial_clk <= 1'b1;
        end
        repeat (13) @(posedge hclk);
        for (k = 1; k <= n; k++) begin
            if (k <= EDGE_MSB && (result_out_chan_a_oe || result_out_chan_b_oe)) early_oe = 1'b1;
            if (!rise_cap && k > EDGE_MSB && k <= EDGE_STD_END + CODE_W) grab();
            serial_clk <= 1'b0;
            repeat (12) @(posedge hclk);
            if (k == 10) begin
                hold_ok    = (track_hold === 1'b1);
                short_seen = (short_inputs === 1'b1);
            end
            if (rise_cap && k >= EDGE_MSB && k < EDGE_STD_END + CODE_W) grab();
            serial_clk <= 1'b1;
            repeat (13) @(posedge hclk);
        end
        end_oe = result_out_chan_a_oe | result_out_chan_b_oe;
        chip_select_n <= 1'b1;
        repeat (6) @(posedge hclk);
        cs_oe = result_out_chan_a_oe | result_out_chan_b_oe;
        repeat (10) @(posedge hclk);
    endtask : frame
endmodule : dadc_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the dual converter readout block
`timescale 1ns/1ps
module tb_top;
    import dadc_pkg::*;
    logic              hclk, hready, hreadyout, hresp, hresetn = 1'b0;
    logic              hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]       hrdata, rd, haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = HSIZE_WORD;
    logic              chip_select_n, serial_clk, offset_cal_pin, track_hold, short_inputs;
    logic              result_out_chan_a, result_out_chan_a_oe;
    logic              result_out_chan_b, result_out_chan_b_oe;
    logic [CODE_W-1:0] conv_code_a = 12'h5A3, conv_code_b = 12'h3C7;
    int                err_count = 0, n_checks = 0;
    assign hready = hreadyout;
    // 200 MHz bus clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    dadc_readout u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .chip_select_n, .serial_clk, .offset_cal_pin,
        .conv_code_a, .conv_code_b, .result_out_chan_a, .result_out_chan_a_oe,
        .result_out_chan_b, .result_out_chan_b_oe, .track_hold, .short_inputs);
    dadc_host_model u_host (
        .hclk, .chip_select_n, .serial_clk, .offset_cal_pin, .result_out_chan_a,
        .result_out_chan_a_oe, .result_out_chan_b, .result_out_chan_b_oe,
        .track_hold, .short_inputs);
    task automatic close_out();
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // single word transfer: address phase, then data phase
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {3'b110, a, wr};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        {hsel, htrans, hwdata} <= {3'b000, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(32'(hresp), 32'(HRESP_OKAY));
    endtask : ahb_xfer
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    // one frame, then both captured streams and the enable history
    task automatic frm(input int n, input logic rc, input logic co, input logic end_on,
                       input logic [PAIR_W-1:0] ea, input logic [PAIR_W-1:0] eb);
        u_host.frame(n, rc, co);
        chk(32'(u_host.cap_a), 32'(ea));
        chk(32'(u_host.cap_b), 32'(eb));
        chk(32'({u_host.hold_ok, u_host.short_seen, u_host.early_oe, u_host.end_oe,
                 u_host.cs_oe}), 32'({3'b100, end_on, 1'b0}));
    endtask : frm
    // main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd_chk(32'h04, 32'h0);
        rd_chk(32'h08, 32'h0);
        rd_chk(32'h10, 32'h0);
        frm(31, 1'b0, 1'b1, 1'b1, 24'h0005A3, 24'h0003C7);
        frm(47, 1'b1, 1'b0, 1'b0, 24'h5A33C7, 24'h3C75A3);
        frm(24, 1'b0, 1'b0, 1'b1, 24'h00000B, 24'h000007);
        // software offsets: clamped positive on A, small unclamped negative on B
        ahb_xfer(1'b1, 32'h08, 32'h1FF);
        ahb_xfer(1'b1, 32'h0C, 32'h810);
        rd_chk(32'h08, 32'h1FF);
        rd_chk(32'h0C, 32'h810);
        frm(31, 1'b0, 1'b0, 1'b1, 24'h000523, 24'h0003D7);
        rd_chk(32'h00, 32'h03D70523);
        // pin calibration held over two frames, then released
        u_host.set_cal(1'b1);
        conv_code_a <= 12'h005;
        conv_code_b <= 12'hFFA;
        u_host.frame(31, 1'b0, 1'b0);
        chk(32'(u_host.short_seen), 32'h1);
        rd_chk(32'h08, 32'h005);
        rd_chk(32'h0C, 32'h806);
        conv_code_a <= 12'h00A;
        u_host.frame(31, 1'b0, 1'b0);
        rd_chk(32'h08, 32'h00A);
        u_host.set_cal(1'b0);
        conv_code_a <= 12'h100;
        conv_code_b <= 12'h100;
        frm(31, 1'b0, 1'b0, 1'b1, 24'h0000F6, 24'h000106);
        // control bit written mid conversion, then its calibration
        fork
            u_host.frame(31, 1'b0, 1'b0);
            begin
                repeat (60) @(posedge hclk);
                ahb_xfer(1'b1, 32'h04, 32'h080);
            end
        join
        rd_chk(32'h04, 32'h080);
        ahb_xfer(1'b0, 32'h00, 32'h0);
        chk(32'(rd[STAT_BAD_BIT]), 32'h1);
        conv_code_a <= 12'hF80;
        conv_code_b <= 12'h0C8;
        u_host.frame(31, 1'b0, 1'b0);
        chk(32'(u_host.short_seen), 32'h1);
        rd_chk(32'h04, 32'h000);
        rd_chk(32'h08, 32'h880);
        rd_chk(32'h0C, 32'h080);
        conv_code_a <= 12'h7FF;
        conv_code_b <= 12'h000;
        frm(31, 1'b0, 1'b0, 1'b1, 24'h0007FF, 24'h000F80);
        close_out();
    end
    // cut a hang short
    initial begin
        #400000;
        err_count++;
        close_out();
    end
endmodule : tb_top
